// *** hw/t1c_top.sv ***
// Overview of operation
// - code 00 pin clock; 01 fallback when idle
// - code 10 scaled clock, 11 recovered clock
// - pointer bits pick functions a write sets
// - masked status bits only drive interrupt
// - reset clears every writable register
// - two info registers flag pending status
// - pin disable bit silences interrupt pin
// - insert enable sources robbed-bit signaling
// - clear channel passes data untouched but for D4 yellow bit 2
// - D4 yellow forces bit 2 low
// - both override bits stuff all channels
// - customer AIS sent, received flag raised
// - ESF customer remote alarm, code 011111
// - milliwatt select replaces receive channel data
// - blue set at five or fewer zeros per window
// - bit-2 yellow uses 254 of 256
// - 12th F-bit yellow needs two alike
// - ESF yellow on 16 00FF patterns
// - red at 192 zeros, clears 14/112
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "t1c_map.svh"
module t1c_top #(
  parameter int BLUE_CYC = `T1C_BLUE_NS / `T1C_CLK_NS,
  parameter int SCALE_DIV = 4
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_clock_pin,
  input  wire logic        rx_line_clk,
  input  wire logic        rx_line_data,
  input  wire logic        rx_frame_sync,
  input  wire logic        tx_byte_vld,
  input  wire logic [4:0]  tx_chan,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_rob_frame,
  input  wire logic        tx_rob_b,
  input  wire logic        rx_fdl_vld,
  input  wire logic [15:0] rx_fdl_pat,
  input  wire logic        rx_boc_vld,
  input  wire logic [5:0]  rx_boc,
  input  wire logic        rx_ais_ci_det,
  output var  logic        tx_clock_out,
  output var  logic        tx_out_vld,
  output var  logic [7:0]  tx_out_byte,
  output var  logic        rx_bp_vld,
  output var  logic        rx_bp_data,
  output var  logic        tx_send_ais,
  output var  logic        tx_send_ais_ci,
  output var  logic        tx_send_rai_ci,
  output var  logic        tx_send_yellow,
  output var  logic        irq_n
);
  import t1c_pkg::*;
  localparam int CHAN_CYC = (`T1C_CHAN_NS + `T1C_CLK_NS - 1) / `T1C_CLK_NS;

  typedef struct packed {
    logic              awr, bv, arr, rv;
    logic [1:0]        br, rr;
    logic [31:0]       rd;
    logic [1:0]        cc1, pcp, sr4, imr4, rx2, lcc;
    logic              interrupt_pin_disable, tx2;
    logic [31:0]       sie, dmw;
    logic [2:0]        sr1, imr1, live, alp;
    logic [3:0]        tx1;
    logic [11:0][7:0]  ts;
    logic [3:0]        s1, s2;
    logic [1:0]        s3;
    logic [7:0]        bcnt, idle, div;
    logic [3:0]        mf;
    logic [2:0]        dmi;
    logic              fail, mclk, tck, irqn, tov, rbv, rbd;
    logic [7:0]        txo;
    logic [3:0]        snd;
  } t1c_top_t;

  t1c_top_t q, d;
  t1c_rx_if rxi ();

  t1c_alarm #(
    .BLUE_CYC (BLUE_CYC)
  ) u_alarm (
    .clk  (clk),
    .srst (srst),
    .rx   (rxi)
  );

  function automatic logic [7:0] byte_of(input logic [31:0] v, input logic [1:0] i);
    byte_of = v[8*i +: 8];
  endfunction : byte_of

  function automatic logic [31:0] put_byte(input logic [31:0] v, input logic [1:0] i,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = v;
    r[8*i +: 8] = b;
    put_byte = r;
  endfunction : put_byte

  logic        wr_go, rd_go, in_pcd_w, in_pcd_r, rclk_rise, tpin_edge, is_f;
  logic        pend1, pend4, stuff_all, clr_ch, d4;
  logic [7:0]  wb, pos, txb, pat;
  logic [4:0]  rch;
  logic [2:0]  rbit, al_rise;
  logic [1:0]  wi, ri;
  logic [3:0]  tsi_w, tsi_r, nib;
  logic [31:0] rmux;
  logic        rerr;

  assign rxi.bit_stb  = rclk_rise;
  assign rxi.bit_val  = q.s2[1];
  assign rxi.chan_b2  = rclk_rise && !is_f && rbit == 3'd1;
  assign rxi.f12_stb  = rclk_rise && is_f && q.mf == `T1C_MFLAST;
  assign rxi.f12_val  = q.s2[1];
  assign rxi.fdl_stb  = rx_fdl_vld;
  assign rxi.fdl_pat  = rx_fdl_pat;
  assign rxi.f12_mode = q.rx2[0];
  assign rxi.esf_mode = q.rx2[1];

  always_comb
  begin
    d = q;
    // second stage alone reads the first; edges are found on the second
    d.s1 = {rx_frame_sync, tx_clock_pin, rx_line_data, rx_line_clk};
    d.s2 = q.s1;
    d.s3 = {q.s2[2], q.s2[0]};
    rclk_rise = q.s2[0] && !q.s3[0];
    tpin_edge = q.s2[2] != q.s3[1];
    pos  = q.bcnt - 8'd1;
    is_f = q.bcnt == 8'd0;
    rch  = pos[7:3];
    rbit = pos[2:0];

    // register write: address and data are taken in the same cycle
    wr_go    = q.awr && s_axi_awvalid && s_axi_wvalid;
    wb       = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
    wi       = 2'(s_axi_awaddr[7:2] - `T1C_A_PCD1 / 4);
    tsi_w    = 4'(s_axi_awaddr[7:2] - `T1C_A_TS1 / 4);
    in_pcd_w = s_axi_awaddr >= `T1C_A_PCD1 && s_axi_awaddr <= `T1C_A_PCD4;
    d.awr    = !q.awr && !q.bv && s_axi_awvalid && s_axi_wvalid;
    if (q.bv && s_axi_bready)
      d.bv = 1'b0;
    al_rise = {rxi.blue, rxi.yellow, rxi.red} & ~q.alp;
    d.alp   = {rxi.blue, rxi.yellow, rxi.red};
    d.live  = q.alp;
    // hardware sets win over a same-cycle clear by software in SR1; in SR4 only for bits not already set
    d.sr1 = q.sr1 | al_rise;
    d.sr4 = q.sr4 | {rx_boc_vld && rx_boc == `T1C_RAICI, rx_ais_ci_det};
    if (wr_go)
    begin
      d.bv = 1'b1;
      d.br = `T1C_RESP_OK;
      unique case (s_axi_awaddr)
        `T1C_A_CC1:  d.cc1    = wb[1:0];
        `T1C_A_CC3:  d.interrupt_pin_disable = wb[`T1C_INTERRUPT_PIN_DISABLE];
        `T1C_A_PCP:  d.pcp    = wb[1:0];
        `T1C_A_SR1:  d.sr1    = (q.sr1 & ~wb[2:0]) | al_rise;
        `T1C_A_IMR1: d.imr1   = wb[2:0];
        `T1C_A_SR4:  d.sr4    = (q.sr4 & ~wb[1:0]) | d.sr4 & ~q.sr4;
        `T1C_A_IMR4: d.imr4   = wb[1:0];
        `T1C_A_TX1:  d.tx1    = wb[3:0];
        `T1C_A_TX2:  d.tx2    = wb[0];
        `T1C_A_RX2:  d.rx2    = wb[1:0];
        `T1C_A_LCC:  d.lcc    = wb[1:0];
        default:
        begin
          if (in_pcd_w)
          begin
            // one write lands in every function the pointer selects
            if (q.pcp[0])
              d.sie = put_byte(q.sie, wi, wb);
            if (q.pcp[1])
              d.dmw = put_byte(q.dmw, wi, wb);
          end
          else if (s_axi_awaddr >= `T1C_A_TS1 && s_axi_awaddr <= `T1C_A_TS12
                   && s_axi_awaddr[1:0] == 2'b00)
            d.ts[tsi_w] = wb;
          else
            d.br = `T1C_RESP_ER;
        end
      endcase
    end

    // register read
    rd_go    = q.arr && s_axi_arvalid;
    ri       = 2'(s_axi_araddr[7:2] - `T1C_A_PCD1 / 4);
    tsi_r    = 4'(s_axi_araddr[7:2] - `T1C_A_TS1 / 4);
    in_pcd_r = s_axi_araddr >= `T1C_A_PCD1 && s_axi_araddr <= `T1C_A_PCD4;
    pend1    = |(q.sr1 & q.imr1);
    pend4    = |(q.sr4 & q.imr4);
    rerr     = 1'b0;
    rmux     = 32'h0000_0000;
    unique case (s_axi_araddr)
      `T1C_A_CC1:  rmux[1:0] = q.cc1;
      `T1C_A_CC3:  rmux[`T1C_INTERRUPT_PIN_DISABLE] = q.interrupt_pin_disable;
      `T1C_A_PCP:  rmux[1:0] = q.pcp;
      `T1C_A_SR1:  rmux[2:0] = q.sr1;
      `T1C_A_IMR1: rmux[2:0] = q.imr1;
      `T1C_A_SR4:  rmux[1:0] = q.sr4;
      `T1C_A_IMR4: rmux[1:0] = q.imr4;
      `T1C_A_IIR1: rmux[0] = pend1;
      `T1C_A_IIR2: rmux[0] = pend4;
      `T1C_A_TX1:  rmux[3:0] = q.tx1;
      `T1C_A_TX2:  rmux[0] = q.tx2;
      `T1C_A_RX2:  rmux[1:0] = q.rx2;
      `T1C_A_LCC:  rmux[1:0] = q.lcc;
      `T1C_A_LIVE: rmux[2:0] = q.live;
      default:
      begin
        // with several pointer bits set the lowest one is shown
        if (in_pcd_r)
          rmux[7:0] = q.pcp[0] ? byte_of(q.sie, ri) : byte_of(q.dmw, ri);
        else if (s_axi_araddr >= `T1C_A_TS1 && s_axi_araddr <= `T1C_A_TS12
                 && s_axi_araddr[1:0] == 2'b00)
          rmux[7:0] = q.ts[tsi_r];
        else
          rerr = 1'b1;
      end
    endcase
    d.arr = !q.arr && !q.rv && s_axi_arvalid;
    if (q.rv && s_axi_rready)
      d.rv = 1'b0;
    if (rd_go)
    begin
      d.rv = 1'b1;
      d.rd = rmux;
      d.rr = rerr ? `T1C_RESP_ER : `T1C_RESP_OK;
    end

    // interrupt pin: only masked status, and quiet while disabled
    d.irqn = !((pend1 || pend4) && !q.interrupt_pin_disable);

    // transmit clock source
    d.idle = tpin_edge ? 8'd0 : (q.idle == 8'(CHAN_CYC)) ? q.idle : q.idle + 8'd1;
    d.fail = q.idle == 8'(CHAN_CYC);
    d.div  = (q.div == 8'(SCALE_DIV - 1)) ? 8'd0 : q.div + 8'd1;
    if (q.div == 8'(SCALE_DIV - 1))
      d.mclk = !q.mclk;
    unique case (t1c_csel_t'(q.cc1))
      CS_PIN:    d.tck = q.s2[2];
      CS_PIN_FB: d.tck = q.fail ? q.s2[0] : q.s2[2];
      CS_SCALED: d.tck = q.mclk;
      CS_RECOV:  d.tck = q.s2[0];
    endcase

    // receive bit position and milliwatt overwrite
    d.rbv = rclk_rise;
    if (rclk_rise)
    begin
      // the sync rise carries the framing bit itself, so the bit after it is position 1
      d.bcnt = q.s2[3] ? 8'd1 : (q.bcnt == `T1C_FBITS) ? 8'd0 : q.bcnt + 8'd1;
      if (q.s2[3])
        d.mf = 4'd0;
      else if (q.bcnt == `T1C_FBITS)
        d.mf = (q.mf == `T1C_MFLAST) ? 4'd0 : q.mf + 4'd1;
      if (q.bcnt == `T1C_FBITS)
        d.dmi = q.dmi + 3'd1;
      pat   = 8'(`T1C_DMW >> (8 * (7 - q.dmi)));
      d.rbd = (!is_f && q.dmw[rch]) ? pat[3'd7 - rbit] : q.s2[1];
    end
    else
      pat = 8'h00;

    // transmit channel processing
    stuff_all = q.tx1[`T1C_TX1_STF] && q.tx2;
    clr_ch    = !q.sie[tx_chan] && !stuff_all;
    d4        = !q.rx2[1];
    nib       = tx_chan[0] ? q.ts[tx_chan[4:1]][3:0] : q.ts[tx_chan[4:1]][7:4];
    txb       = tx_byte;
    if (!clr_ch && txb == 8'h00)
      txb[1] = 1'b1;
    if (q.sie[tx_chan] && tx_rob_frame)
      txb[0] = tx_rob_b ? nib[2] : nib[3];
    if (d4 && q.tx1[`T1C_TX1_YEL])
      txb[6] = 1'b0;
    d.tov = tx_byte_vld;
    if (tx_byte_vld)
      d.txo = txb;
    d.snd = {q.tx1[`T1C_TX1_YEL],
             q.lcc[1] && q.rx2[1],
             q.lcc[0] && q.tx1[`T1C_TX1_BLU],
             q.tx1[`T1C_TX1_BLU]};
  end

  // every writable register comes out of reset at zero
  always_ff @(posedge clk)
    if (srst)
    begin
      q      <= '0;
      q.irqn <= 1'b1;
    end
    else
      q <= d;

  assign s_axi_awready  = q.awr;
  assign s_axi_wready   = q.awr;
  assign s_axi_bresp    = q.br;
  assign s_axi_bvalid   = q.bv;
  assign s_axi_arready  = q.arr;
  assign s_axi_rdata    = q.rd;
  assign s_axi_rresp    = q.rr;
  assign s_axi_rvalid   = q.rv;
  assign tx_clock_out   = q.tck;
  assign tx_out_vld     = q.tov;
  assign tx_out_byte    = q.txo;
  assign rx_bp_vld      = q.rbv;
  assign rx_bp_data     = q.rbd;
  assign tx_send_ais    = q.snd[0];
  assign tx_send_ais_ci = q.snd[1];
  assign tx_send_rai_ci = q.snd[2];
  assign tx_send_yellow = q.snd[3];
  assign irq_n          = q.irqn;

  property p_irq_on;
    @(posedge clk) disable iff (srst)
    ((pend1 || pend4) && !q.interrupt_pin_disable) |=> !irq_n;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("unmasked event missed");
  property p_interrupt_pin_disable;
    @(posedge clk) disable iff (srst)
    q.interrupt_pin_disable |=> irq_n;
  endproperty
  a_interrupt_pin_disable: assert property (p_interrupt_pin_disable) else $error("pin active while off");
  property p_rst;
    @(posedge clk)
    srst |=> (q.imr1 == 3'd0 && q.imr4 == 2'd0 && irq_n && q.cc1 == 2'd0);
  endproperty
  a_rst: assert property (p_rst) else $error("reset left state");
  property p_recov;
    @(posedge clk) disable iff (srst)
    (q.cc1 == 2'b11) |=> tx_clock_out == $past(q.s2[0]);
  endproperty
  a_recov: assert property (p_recov) else $error("wrong tx clock");
  property p_clear;
    @(posedge clk) disable iff (srst)
    (tx_byte_vld && clr_ch && !q.tx1[`T1C_TX1_YEL])
      |=> tx_out_byte == $past(tx_byte);
  endproperty
  a_clear: assert property (p_clear) else $error("clear channel altered");
  property p_c_irq;
    @(posedge clk) disable iff (srst) $fell(irq_n);
  endproperty
  c_irq: cover property (p_c_irq);
endmodule : t1c_top
`default_nettype wire

// *** hw/t1c_map.svh ***
`ifndef T1C_MAP_SVH
`define T1C_MAP_SVH
`define T1C_A_CC1   8'h00
`define T1C_A_CC3   8'h04
`define T1C_A_PCP   8'h08
`define T1C_A_PCD1  8'h0C
`define T1C_A_PCD4  8'h18
`define T1C_A_SR1   8'h1C
`define T1C_A_IMR1  8'h20
`define T1C_A_SR4   8'h24
`define T1C_A_IMR4  8'h28
`define T1C_A_IIR1  8'h2C
`define T1C_A_IIR2  8'h30
`define T1C_A_TX1   8'h34
`define T1C_A_TX2   8'h38
`define T1C_A_RX2   8'h3C
`define T1C_A_LCC   8'h40
`define T1C_A_LIVE  8'h44
`define T1C_A_TS1   8'h80
`define T1C_A_TS12  8'hAC
`define T1C_INTERRUPT_PIN_DISABLE  6
`define T1C_TX1_YEL 0
`define T1C_TX1_BLU 1
`define T1C_TX1_STF 3
`define T1C_CLK_NS  40
`define T1C_CHAN_NS 5181
`define T1C_BLUE_NS 3000000
`define T1C_FBITS   8'd192
`define T1C_MFLAST  4'd11
`define T1C_DMW     64'h1E0B_0B1E_9E8B_8B9E
`define T1C_RAICI   6'h1F
`define T1C_RESP_OK 2'h0
`define T1C_RESP_ER 2'h2
`define T1C_RED_RUN 8'd192
`define T1C_RED_WIN 7'd111
`define T1C_RED_ONE 4'd14
`define T1C_BLU_MAX 3'd5
`define T1C_YEL_LST 8'd255
`define T1C_YEL_MIN 9'd254
`define T1C_FDL_PAT 16'h00FF
`define T1C_FDL_RUN 5'd16
`define T1C_FDL_LST 4'd15
`define T1C_FDL_MAX 5'd14
`endif

// *** hw/t1c_pkg.sv ***
package t1c_pkg;
  typedef enum logic [1:0] {CS_PIN, CS_PIN_FB, CS_SCALED, CS_RECOV} t1c_csel_t;
  typedef struct packed {
    logic        blue, red, yel, f12p;
    logic [19:0] bwin;
    logic [2:0]  zc;
    logic [7:0]  zrun;
    logic [6:0]  rwin;
    logic [3:0]  rones;
    logic [7:0]  ych;
    logic [8:0]  yz;
    logic [4:0]  frun, fhit;
    logic [3:0]  fwin;
  } t1c_al_t;
endpackage : t1c_pkg

// *** hw/t1c_rx_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface t1c_rx_if;
  logic        bit_stb, bit_val, chan_b2, f12_stb, f12_val;
  logic        fdl_stb, f12_mode, esf_mode, red, yellow, blue;
  logic [15:0] fdl_pat;
  modport src (output bit_stb, bit_val, chan_b2, f12_stb, f12_val, fdl_stb,
               fdl_pat, f12_mode, esf_mode, input red, yellow, blue);
  modport det (input bit_stb, bit_val, chan_b2, f12_stb, f12_val, fdl_stb,
               fdl_pat, f12_mode, esf_mode, output red, yellow, blue);
endinterface : t1c_rx_if
`default_nettype wire

// *** hw/t1c_alarm.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "t1c_map.svh"
module t1c_alarm #(
  parameter int BLUE_CYC = `T1C_BLUE_NS / `T1C_CLK_NS
) (
  input wire logic clk,
  input wire logic srst,
  t1c_rx_if.det    rx
);
  import t1c_pkg::*;
  t1c_al_t q, d;
  logic    wend;
  logic [2:0] zc_nx;
  logic [3:0] ro_nx;
  logic [8:0] yz_nx;
  logic [4:0] fh_nx;
  logic       hit;
  always_comb
  begin
    d     = q;
    wend  = (q.bwin == 20'(BLUE_CYC - 1));
    zc_nx = q.zc + 3'((rx.bit_stb && !rx.bit_val && q.zc != 3'd6) ? 1 : 0);
    ro_nx = q.rones + 4'((rx.bit_stb && rx.bit_val && q.rones != `T1C_RED_ONE) ? 1 : 0);
    yz_nx = q.yz + 9'((rx.chan_b2 && !rx.bit_val) ? 1 : 0);
    hit   = rx.fdl_pat == `T1C_FDL_PAT;
    fh_nx = q.fhit + 5'(hit ? 1 : 0);
    // window is measured in time, not bits, so a stopped line still resolves
    d.bwin = wend ? 20'd0 : q.bwin + 20'd1;
    d.zc   = wend ? 3'd0 : zc_nx;
    if (wend)
      d.blue = zc_nx <= `T1C_BLU_MAX;
    if (rx.bit_stb)
    begin
      d.rwin  = (q.rwin == `T1C_RED_WIN) ? 7'd0 : q.rwin + 7'd1;
      d.rones = (q.rwin == `T1C_RED_WIN) ? 4'd0 : ro_nx;
      if (q.rwin == `T1C_RED_WIN && ro_nx >= `T1C_RED_ONE)
        d.red = 1'b0;
      d.zrun = rx.bit_val ? 8'd0 : (q.zrun == `T1C_RED_RUN) ? q.zrun : q.zrun + 8'd1;
      if (d.zrun == `T1C_RED_RUN)
        d.red = 1'b1;
    end
    if (rx.esf_mode && rx.fdl_stb)
    begin
      d.frun = !hit ? 5'd0 : (q.frun == `T1C_FDL_RUN) ? q.frun : q.frun + 5'd1;
      d.fwin = q.fwin + 4'd1;
      d.fhit = (q.fwin == `T1C_FDL_LST) ? 5'd0 : fh_nx;
      if (q.fwin == `T1C_FDL_LST && fh_nx <= `T1C_FDL_MAX)
        d.yel = 1'b0;
      if (d.frun == `T1C_FDL_RUN)
        d.yel = 1'b1;
    end
    else if (!rx.esf_mode && rx.f12_mode && rx.f12_stb)
    begin
      d.f12p = rx.f12_val;
      if (rx.f12_val == q.f12p)
        d.yel = rx.f12_val;
    end
    else if (!rx.esf_mode && !rx.f12_mode && rx.chan_b2)
    begin
      d.ych = q.ych + 8'd1;
      d.yz  = (q.ych == `T1C_YEL_LST) ? 9'd0 : yz_nx;
      if (q.ych == `T1C_YEL_LST)
        d.yel = yz_nx >= `T1C_YEL_MIN;
    end
  end
  always_ff @(posedge clk)
    if (srst)
      q <= '0;
    else
      q <= d;
  assign rx.red    = q.red;
  assign rx.yellow = q.yel;
  assign rx.blue   = q.blue;

  property p_red_set;
    @(posedge clk) disable iff (srst)
    (rx.bit_stb && !rx.bit_val && q.zrun == 8'd191) |=> q.red;
  endproperty
  a_red_set: assert property (p_red_set) else $error("red not set on zeros");
  property p_f12;
    @(posedge clk) disable iff (srst)
    (!rx.esf_mode && rx.f12_mode && rx.f12_stb && rx.f12_val && q.f12p) |=> q.yel;
  endproperty
  a_f12: assert property (p_f12) else $error("f-bit yellow missed");
  property p_blue_hold;
    @(posedge clk) disable iff (srst)
    !wend |=> $stable(q.blue);
  endproperty
  a_blue_hold: assert property (p_blue_hold) else $error("blue moved mid window");
  property p_c_red;
    @(posedge clk) disable iff (srst) $rose(q.red);
  endproperty
  c_red: cover property (p_c_red);
  property p_c_yel;
    @(posedge clk) disable iff (srst) $fell(q.yel);
  endproperty
  c_yel: cover property (p_c_yel);
endmodule : t1c_alarm
`default_nettype wire

// *** bench/t1c_line_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module t1c_line_model (
  output var logic rx_line_clk,
  output var logic rx_line_data,
  output var logic rx_frame_sync
);
  initial
  begin
    rx_line_clk   = 1'b0;
    rx_line_data  = 1'b1;
    rx_frame_sync = 1'b0;
  end
  // the link clock stands still between bursts; idle data flips so nothing stale is held
  task automatic send_bits(input int n, input logic b);
    #7;
    for (int i = 0; i < n; i++)
    begin
      rx_line_data = b;
      #160 rx_line_clk = 1'b1;
      #160 rx_line_clk = 1'b0;
    end
    rx_line_data = ~b;
  endtask : send_bits
  // frame sync stands around the rise that carries the framing bit
  task automatic send_fbit(input logic b);
    #7 rx_frame_sync = 1'b1;
    send_bits(1, b);
    rx_frame_sync = 1'b0;
  endtask : send_fbit
endmodule : t1c_line_model
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "t1c_map.svh"
module tb_top;
  logic        clk = 1'b0, srst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_byte = 8'h00, tx_out_byte;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_clock_pin = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        tx_byte_vld = 1'b0, tx_rob_frame = 1'b0, rx_fdl_vld = 1'b0;
  logic        rx_boc_vld = 1'b0, rx_ais_ci_det = 1'b0, tx_rob_b = 1'b0, last;
  logic [7:0]  bp_sr = 8'h00;
  logic [4:0]  tx_chan = 5'h00;
  logic [15:0] rx_fdl_pat = 16'h0000;
  logic [5:0]  rx_boc = 6'h00;
  logic        rx_line_clk, rx_line_data, rx_frame_sync, tx_clock_out, tx_out_vld;
  logic        rx_bp_vld, rx_bp_data, irq_n, tx_send_ais, tx_send_ais_ci;
  logic        tx_send_rai_ci, tx_send_yellow;
  int          err_count = 0, n_checks = 0, cyc = 0, cnt;
  logic [7:0]  ra [6] = '{`T1C_A_CC1, `T1C_A_CC3, `T1C_A_PCP, `T1C_A_IMR1, `T1C_A_TX1,
                          `T1C_A_LCC};

  always #20 clk = ~clk;

  // backplane bits collected as presented, newest in the low bit
  always @(posedge clk)
    if (rx_bp_vld === 1'b1)
      bp_sr <= {bp_sr[6:0], rx_bp_data};

  t1c_line_model line (.rx_line_clk, .rx_line_data, .rx_frame_sync);
  t1c_top #(.BLUE_CYC(200)) dut (
    .clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_clock_pin, .rx_line_clk,
    .rx_line_data, .rx_frame_sync, .tx_byte_vld, .tx_chan, .tx_byte, .tx_rob_frame,
    .tx_rob_b, .rx_fdl_vld, .rx_fdl_pat, .rx_boc_vld, .rx_boc, .rx_ais_ci_det,
    .tx_clock_out, .tx_out_vld, .tx_out_byte, .rx_bp_vld, .rx_bp_data, .tx_send_ais,
    .tx_send_ais_ci, .tx_send_rai_ci, .tx_send_yellow, .irq_n);

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
    chk({30'h0, r}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
    chk({30'h0, r}, {30'h0, er});
  endtask : rd

  task automatic txb(input logic [4:0] c, input logic [7:0] b, input logic rob,
                     input logic [7:0] e);
    tx_chan <= c;
    tx_byte <= b;
    tx_rob_frame <= rob;
    tx_byte_vld <= 1'b1;
    @(posedge clk);
    tx_byte_vld <= 1'b0;
    @(posedge clk);
    chk({31'h0, tx_out_vld}, 32'h1);
    chk({24'h0, tx_out_byte}, {24'h0, e});
  endtask : txb

  task automatic fdl(input int n, input logic [15:0] p);
    for (int i = 0; i < n; i++)
    begin
      rx_fdl_pat <= p;
      rx_fdl_vld <= 1'b1;
      @(posedge clk);
      rx_fdl_vld <= 1'b0;
      @(posedge clk);
    end
  endtask : fdl

  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (ra[i])
    begin
      rd(ra[i], v);
      chk(v, 32'h0);
    end
    chk({31'h0, irq_n}, 32'h1);
    rd(8'h7C, v, `T1C_RESP_ER);
    chk(v, 32'h0);
    wr(8'h7C, 32'h55, `T1C_RESP_ER);
    $display("test registers done");
    tx_clock_pin <= 1'b1;
    repeat (8) @(posedge clk);
    chk({31'h0, tx_clock_out}, 32'h1);
    wr(`T1C_A_CC1, 32'h3);
    repeat (8) @(posedge clk);
    chk({31'h0, tx_clock_out}, 32'h0);
    wr(`T1C_A_CC1, 32'h2);
    cnt = 0;
    last = tx_clock_out;
    repeat (64)
    begin
      @(posedge clk);
      if (tx_clock_out !== last) cnt++;
      last = tx_clock_out;
    end
    chk({31'h0, cnt > 4}, 32'h1);
    wr(`T1C_A_CC1, 32'h1);
    repeat (8) @(posedge clk);
    chk({31'h0, tx_clock_out}, 32'h1);
    repeat (200) @(posedge clk);
    chk({31'h0, tx_clock_out}, 32'h0);
    tx_clock_pin <= 1'b0;
    @(posedge clk);
    tx_clock_pin <= 1'b1;
    repeat (8) @(posedge clk);
    chk({31'h0, tx_clock_out}, 32'h1);
    $display("test clock select done");
    wr(`T1C_A_PCP, 32'h3);
    wr(8'h10, 32'h0F);
    wr(`T1C_A_PCP, 32'h2);
    rd(8'h10, v);
    chk(v, 32'h0F);
    wr(`T1C_A_PCP, 32'h1);
    rd(8'h10, v);
    chk(v, 32'h0F);
    wr(`T1C_A_PCD1, 32'h0);
    txb(5'd3, 8'h00, 1'b0, 8'h00);
    wr(`T1C_A_TX1, 32'h8);
    txb(5'd3, 8'h00, 1'b0, 8'h00);
    wr(`T1C_A_TX2, 32'h1);
    txb(5'd3, 8'h00, 1'b0, 8'h02);
    wr(`T1C_A_TX1, 32'h9);
    txb(5'd5, 8'hFF, 1'b0, 8'hBF);
    chk({31'h0, tx_send_yellow}, 32'h1);
    wr(`T1C_A_TX1, 32'h0);
    wr(`T1C_A_TX2, 32'h0);
    wr(`T1C_A_PCD1, 32'h1);
    wr(`T1C_A_TS1, 32'h80);
    txb(5'd0, 8'hF0, 1'b1, 8'hF1);
    txb(5'd0, 8'hF0, 1'b0, 8'hF0);
    tx_rob_b <= 1'b1;
    wr(`T1C_A_TS1, 32'h40);
    txb(5'd0, 8'hF0, 1'b1, 8'hF1);
    txb(5'd7, 8'h8B, 1'b1, 8'h8B);
    $display("test transmit path done");
    wr(`T1C_A_RX2, 32'h2);
    wr(`T1C_A_TX1, 32'h2);
    wr(`T1C_A_LCC, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, tx_send_ais}, 32'h1);
    chk({31'h0, tx_send_ais_ci}, 32'h1);
    chk({31'h0, tx_send_rai_ci}, 32'h1);
    rx_boc <= 6'h1E;
    rx_boc_vld <= 1'b1;
    @(posedge clk);
    rx_boc_vld <= 1'b0;
    rd(`T1C_A_SR4, v);
    chk(v, 32'h0);
    rx_boc <= `T1C_RAICI;
    rx_boc_vld <= 1'b1;
    rx_ais_ci_det <= 1'b1;
    @(posedge clk);
    rx_boc_vld <= 1'b0;
    rx_ais_ci_det <= 1'b0;
    rd(`T1C_A_SR4, v);
    chk(v, 32'h3);
    wr(`T1C_A_IMR4, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_n}, 32'h0);
    rd(`T1C_A_IIR2, v);
    chk({31'h0, v[0]}, 32'h1);
    wr(`T1C_A_SR4, 32'h3);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_n}, 32'h1);
    wr(`T1C_A_LCC, 32'h0);
    wr(`T1C_A_TX1, 32'h0);
    fdl(16, 16'h00FF);
    rd(`T1C_A_LIVE, v);
    chk({31'h0, v[1]}, 32'h1);
    fdl(32, 16'h0000);
    rd(`T1C_A_LIVE, v);
    chk({31'h0, v[1]}, 32'h0);
    wr(`T1C_A_RX2, 32'h0);
    $display("test customer alarms done");
    line.send_bits(191, 1'b0);
    repeat (10) @(posedge clk);
    rd(`T1C_A_LIVE, v);
    chk({31'h0, v[0]}, 32'h0);
    line.send_bits(1, 1'b0);
    repeat (10) @(posedge clk);
    rd(`T1C_A_LIVE, v);
    chk({31'h0, v[0]}, 32'h1);
    chk({31'h0, irq_n}, 32'h1);
    rd(`T1C_A_SR1, v);
    chk({31'h0, v[0]}, 32'h1);
    wr(`T1C_A_IMR1, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_n}, 32'h0);
    rd(`T1C_A_IIR1, v);
    chk({31'h0, v[0]}, 32'h1);
    wr(`T1C_A_CC3, 32'h40);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_n}, 32'h1);
    wr(`T1C_A_CC3, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_n}, 32'h0);
    line.send_bits(240, 1'b1);
    repeat (10) @(posedge clk);
    rd(`T1C_A_LIVE, v);
    chk({31'h0, v[0]}, 32'h0);
    chk({31'h0, v[2]}, 32'h1);
    line.send_bits(40, 1'b0);
    repeat (10) @(posedge clk);
    rd(`T1C_A_LIVE, v);
    chk({31'h0, v[2]}, 32'h0);
    wr(`T1C_A_SR1, 32'h7);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_n}, 32'h1);
    $display("test line alarms done");
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(`T1C_A_PCP, v);
    chk(v, 32'h0);
    wr(`T1C_A_PCP, 32'h2);
    wr(`T1C_A_PCD1, 32'h1);
    line.send_fbit(1'b1);
    line.send_bits(8, 1'b1);
    repeat (10) @(posedge clk);
    chk({24'h0, bp_sr}, 32'h1E);
    line.send_bits(8, 1'b1);
    repeat (10) @(posedge clk);
    chk({24'h0, bp_sr}, 32'hFF);
    $display("test milliwatt done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
